// *** ltmc_pkg.sv ***
package ltmc_pkg;
	// Filter times in nanoseconds and the core clock period.
	localparam int unsigned CLK_PERIOD_NS   = 25;
	localparam int unsigned T_TXTO_NS       = 20000000;
	localparam int unsigned T_ENABLE_NS     = 10000;
	localparam int unsigned T_DISABLE_NS    = 10000;
	localparam int unsigned T_WAKE_NS       = 50000;
	localparam int unsigned T_BUSWAKE_NS    = 100000;
	// Cycle counts: least times round up.
	localparam int unsigned TXTO_CYC    = (T_TXTO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned ENABLE_CYC  = (T_ENABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned DISABLE_CYC = (T_DISABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned WAKE_CYC    = (T_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned BUSWAKE_CYC = (T_BUSWAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RX_FIFO_DEPTH = 4;
	localparam int unsigned RX_FIFO_WIDTH = 1;

	typedef enum logic [1:0] {
		ST_UNPOWERED = 2'b00,
		ST_STANDBY   = 2'b01,
		ST_NORMAL    = 2'b10,
		ST_SLEEP     = 2'b11
	} ltmc_state_e;

	typedef enum logic [1:0] {
		WK_NONE  = 2'b00,
		WK_BUS   = 2'b01,
		WK_LOCAL = 2'b10
	} ltmc_wake_e;
endpackage

// *** ltmc_top.sv ***
// What this block does
// - Normal mode: bus follows transmit input; receive output shows bus, released when recessive.
// - Transmit low longer than dominant timeout releases the bus to recessive.
// - After timeout, transmission resumes only after transmit input returns high.
// - Over-temperature disables transmitter and holds bus recessive.
// - After over-temperature clears, transmitter waits for a high transmit input.
// - Normal mode: supply low disables transmitter, supply high re-enables it.
// - Supply-disabled transmission keeps normal mode and reception alive.
// - Mode-select high longer than enable filter enters normal from standby or sleep.
// - Standby to normal: weak pull-down and released receive output when mode-select rises.
// - Sleep: transceiver inactive, inhibit released, only weak bus pull-up.
// - Mode-select low longer than disable filter enters sleep from normal.
// - Sleep entry completes even with bus or wake input stuck.
// - Wake during disable filter is valid and leads to standby with wake settings.
// - Local wake: wake input falls, then stays low for the local wake filter.
// - Remote wake: bus dominant longer than bus wake filter, then rising edge.
// - Wake events detected only in sleep or during normal-to-sleep transition.
// - After wake: receive output low; weak pull-down for bus, strong for local.
// - Standby after power-up: receive output released, transmit pull-down weak.
// - Standby: transceiver inactive, inhibit output driven high.
// - Power-on-reset indication forces unpowered state, transmitter off, outputs released.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module ltmc_fifo #(
	parameter int unsigned WIDTH = 1,
	parameter int unsigned DEPTH = 4
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// Fill side.
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// Drain side.
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("ltmc_fifo: DEPTH must be a power of two >= 2");
	end
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0]      wr_r;
	logic [AW:0]      rd_r;
	logic             push;
	logic             pop;
	assign in_ready_o  = (wr_r - rd_r) != (AW+1)'(DEPTH);
	assign out_valid_o = wr_r != rd_r;
	assign out_data_o  = mem_r[rd_r[AW-1:0]];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_r[wr_r[AW-1:0]] <= in_data_i;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_r <= '0;
			rd_r <= '0;
		end else begin
			if (push) begin
				wr_r <= wr_r + 1'b1;
			end
			if (pop) begin
				rd_r <= rd_r + 1'b1;
			end
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Counts while its qualifying level holds, restarts otherwise, saturates at done.
module ltmc_filter #(
	parameter int unsigned COUNT = 4
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic level_i,
	output logic      done_o
);
	localparam int unsigned CW = $clog2(COUNT + 1);
	initial begin
		if (COUNT < 1) $error("ltmc_filter: COUNT must be at least one");
	end
	logic [CW-1:0] cnt_r;
	assign done_o = cnt_r == CW'(COUNT);
	always_ff @(posedge clk_i) begin
		if (rst_i || !level_i) begin
			cnt_r <= '0;
		end else if (!done_o) begin
			cnt_r <= cnt_r + 1'b1;
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
module ltmc_top #(
	parameter int unsigned TXTO_CYC    = ltmc_pkg::TXTO_CYC,
	parameter int unsigned ENABLE_CYC  = ltmc_pkg::ENABLE_CYC,
	parameter int unsigned DISABLE_CYC = ltmc_pkg::DISABLE_CYC,
	parameter int unsigned WAKE_CYC    = ltmc_pkg::WAKE_CYC,
	parameter int unsigned BUSWAKE_CYC = ltmc_pkg::BUSWAKE_CYC,
	parameter int unsigned FIFO_DEPTH  = ltmc_pkg::RX_FIFO_DEPTH
) (
	// Clock and synchronous reset.
	input  wire logic core_clk_i,
	input  wire logic rst_i,
	// Controller side pins.
	input  wire logic txd_i,
	input  wire logic mode_select_i,
	output logic      rxd_o,
	output logic      rxd_oe_o,
	output logic      txd_strong_pd_o,
	// Bus, wake input and inhibit.
	input  wire logic bus_i,
	output logic      bus_dom_o,
	output logic      bus_pullup_o,
	output logic      bus_weak_src_o,
	input  wire logic wake_i,
	output logic      regulator_inhibit_out_o,
	output logic      regulator_inhibit_out_oe_o,
	// Analog monitor indications and mode output.
	input  wire logic por_i,
	input  wire logic over_temperature_shutdown_i,
	input  wire logic supply_monitor_low_i,
	input  wire logic supply_monitor_high_i,
	output logic [1:0] mode_o
);
	// Two-flop synchronisers on every pin input.
	logic [6:0] s1_r;
	logic [6:0] s2_r;
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			s1_r <= 7'h5F;
			s2_r <= 7'h5F;
		end else begin
			s1_r <= {txd_i, mode_select_i, bus_i, wake_i, ~por_i, ~over_temperature_shutdown_i,
				~supply_monitor_low_i};
			s2_r <= s1_r;
		end
	end
	logic txd_s, en_s, bus_s, wake_s, por_s, tsd_s, monl_s;
	assign txd_s  = s2_r[6];
	assign en_s   = s2_r[5];
	assign bus_s  = s2_r[4];
	assign wake_s = s2_r[3];
	assign por_s  = ~s2_r[2];
	assign tsd_s  = ~s2_r[1];
	assign monl_s = ~s2_r[0];
	logic monh_s1_r, monh_s_r;
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			monh_s1_r <= 1'b0;
			monh_s_r  <= 1'b0;
		end else begin
			monh_s1_r <= supply_monitor_high_i;
			monh_s_r  <= monh_s1_r;
		end
	end

	ltmc_pkg::ltmc_state_e state_r;
	ltmc_pkg::ltmc_wake_e  wake_kind_r;
	logic en_done, dis_done, txto_done, lwk_done, bwk_done;
	logic wake_prev_r, lwk_arm_r, bus_prev_r, bwk_armed_r;
	logic en_rise_r, en_prev_r;

	// Filter timers.
	ltmc_filter #(.COUNT(ENABLE_CYC))  u_en   (.clk_i(core_clk_i), .rst_i(rst_i),
		.level_i(en_s && state_r != ltmc_pkg::ST_NORMAL), .done_o(en_done));
	ltmc_filter #(.COUNT(DISABLE_CYC)) u_dis  (.clk_i(core_clk_i), .rst_i(rst_i),
		.level_i(!en_s && state_r == ltmc_pkg::ST_NORMAL), .done_o(dis_done));
	ltmc_filter #(.COUNT(TXTO_CYC))    u_txto (.clk_i(core_clk_i), .rst_i(rst_i),
		.level_i(!txd_s), .done_o(txto_done));
	ltmc_filter #(.COUNT(WAKE_CYC))    u_lwk  (.clk_i(core_clk_i), .rst_i(rst_i),
		.level_i(!wake_s && lwk_arm_r), .done_o(lwk_done));
	ltmc_filter #(.COUNT(BUSWAKE_CYC)) u_bwk  (.clk_i(core_clk_i), .rst_i(rst_i),
		.level_i(!bus_s), .done_o(bwk_done));

	// Wake detection window: sleep, or normal with the disable filter running.
	logic wake_window;
	assign wake_window = state_r == ltmc_pkg::ST_SLEEP ||
		(state_r == ltmc_pkg::ST_NORMAL && !en_s);
	logic local_wake, bus_wake;
	assign local_wake = wake_window && lwk_done;
	assign bus_wake   = wake_window && bwk_armed_r && bus_s && !bus_prev_r;

	// A falling edge arms the local filter; a rise disarms it.
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			wake_prev_r <= 1'b1;
			lwk_arm_r   <= 1'b0;
			bus_prev_r  <= 1'b1;
			bwk_armed_r <= 1'b0;
		end else begin
			wake_prev_r <= wake_s;
			bus_prev_r  <= bus_s;
			if (wake_s || !wake_window) begin
				lwk_arm_r <= 1'b0;
			end else if (wake_prev_r) begin
				lwk_arm_r <= 1'b1;
			end
			if (!wake_window || bus_s) begin
				bwk_armed_r <= 1'b0;
			end else if (bwk_done) begin
				bwk_armed_r <= 1'b1;
			end
		end
	end

	// Mode sequencing.
	always_ff @(posedge core_clk_i) begin
		if (rst_i || por_s) begin
			state_r     <= ltmc_pkg::ST_UNPOWERED;
			wake_kind_r <= ltmc_pkg::WK_NONE;
		end else begin
			case (state_r)
				ltmc_pkg::ST_UNPOWERED: begin
					state_r     <= ltmc_pkg::ST_STANDBY;
					wake_kind_r <= ltmc_pkg::WK_NONE;
				end
				ltmc_pkg::ST_STANDBY: begin
					if (en_done) begin
						state_r <= ltmc_pkg::ST_NORMAL;
					end
				end
				ltmc_pkg::ST_NORMAL: begin
					if (local_wake || bus_wake) begin
						state_r     <= ltmc_pkg::ST_STANDBY;
						wake_kind_r <= local_wake ? ltmc_pkg::WK_LOCAL : ltmc_pkg::WK_BUS;
					end else if (dis_done) begin
						state_r <= ltmc_pkg::ST_SLEEP;
					end
				end
				ltmc_pkg::ST_SLEEP: begin
					if (en_done) begin
						state_r     <= ltmc_pkg::ST_NORMAL;
						wake_kind_r <= ltmc_pkg::WK_NONE;
					end else if (local_wake || bus_wake) begin
						state_r     <= ltmc_pkg::ST_STANDBY;
						wake_kind_r <= local_wake ? ltmc_pkg::WK_LOCAL : ltmc_pkg::WK_BUS;
					end
				end
				default: begin
					state_r <= ltmc_pkg::ST_UNPOWERED;
				end
			endcase
		end
	end

	// Transmit interlocks: timeout, thermal and supply.
	logic txto_lock_r, tsd_lock_r, mon_lock_r;
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			txto_lock_r <= 1'b0;
			tsd_lock_r  <= 1'b0;
			mon_lock_r  <= 1'b0;
		end else begin
			if (txto_done) begin
				txto_lock_r <= 1'b1;
			end else if (txd_s) begin
				txto_lock_r <= 1'b0;
			end
			if (tsd_s) begin
				tsd_lock_r <= 1'b1;
			end else if (txd_s) begin
				tsd_lock_r <= 1'b0;
			end
			if (monl_s) begin
				mon_lock_r <= 1'b1;
			end else if (monh_s_r) begin
				mon_lock_r <= 1'b0;
			end
		end
	end

	// Mode-select rise seen while in standby releases the standby pin setup.
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			en_prev_r <= 1'b0;
			en_rise_r <= 1'b0;
		end else begin
			en_prev_r <= en_s;
			if (state_r != ltmc_pkg::ST_STANDBY) begin
				en_rise_r <= 1'b0;
			end else if (en_s && !en_prev_r) begin
				en_rise_r <= 1'b1;
			end
		end
	end

	// Registered outputs.
	logic rx_valid;
	logic rx_data;
	logic normal;
	logic tx_ok;
	logic standby_wake;
	assign normal       = state_r == ltmc_pkg::ST_NORMAL;
	assign tx_ok        = normal && !txto_lock_r && !tsd_lock_r && !mon_lock_r && !tsd_s;
	assign standby_wake = state_r == ltmc_pkg::ST_STANDBY && wake_kind_r != ltmc_pkg::WK_NONE
		&& !en_rise_r && !(en_s && !en_prev_r);
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			bus_dom_o                  <= 1'b0;
			rxd_o                      <= 1'b0;
			rxd_oe_o                   <= 1'b0;
			txd_strong_pd_o            <= 1'b0;
			bus_pullup_o               <= 1'b0;
			bus_weak_src_o             <= 1'b0;
			regulator_inhibit_out_o    <= 1'b0;
			regulator_inhibit_out_oe_o <= 1'b0;
			mode_o                     <= ltmc_pkg::ST_UNPOWERED;
		end else begin
			bus_dom_o       <= tx_ok && !txd_s;
			rxd_o           <= 1'b0;
			rxd_oe_o        <= (normal && rx_valid && !rx_data) || standby_wake;
			txd_strong_pd_o <= standby_wake && wake_kind_r == ltmc_pkg::WK_LOCAL;
			bus_pullup_o    <= normal || state_r == ltmc_pkg::ST_STANDBY;
			bus_weak_src_o  <= state_r == ltmc_pkg::ST_SLEEP;
			regulator_inhibit_out_o    <= normal || state_r == ltmc_pkg::ST_STANDBY;
			regulator_inhibit_out_oe_o <= normal || state_r == ltmc_pkg::ST_STANDBY;
			mode_o          <= state_r;
		end
	end

	// Received symbols pass through a small FIFO on their way to the receive output.
	ltmc_fifo #(.WIDTH(ltmc_pkg::RX_FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_rxq (
		.clk_i(core_clk_i), .rst_i(rst_i),
		.in_valid_i(normal), .in_ready_o(), .in_data_i(bus_s),
		.out_valid_o(rx_valid), .out_ready_i(1'b1), .out_data_o(rx_data));

	// Assertions.
	a_tsd_holds_recessive: assert property (@(posedge core_clk_i) disable iff (rst_i)
		tsd_lock_r |=> !bus_dom_o) else $error("dominant driven under thermal lock");
	a_tsd_needs_high: assert property (@(posedge core_clk_i) disable iff (rst_i)
		$fell(tsd_s) && !txd_s |=> tsd_lock_r) else $error("thermal lock left without high txd");
	a_txto_release: assert property (@(posedge core_clk_i) disable iff (rst_i)
		txto_done |=> txto_lock_r ##1 !bus_dom_o) else $error("timeout did not release bus");
	a_txto_resume: assert property (@(posedge core_clk_i) disable iff (rst_i)
		txto_lock_r && !txd_s |=> txto_lock_r) else $error("timeout lock cleared while low");
	a_mon_stays_normal: assert property (@(posedge core_clk_i) disable iff (rst_i || por_s)
		mon_lock_r && normal && en_s |=> normal) else $error("supply lock left normal");
	a_enter_normal: assert property (@(posedge core_clk_i) disable iff (rst_i || por_s)
		en_done && state_r == ltmc_pkg::ST_STANDBY |=> normal) else $error("no normal entry");
	a_enter_sleep: assert property (@(posedge core_clk_i) disable iff (rst_i || por_s)
		dis_done && normal && !local_wake && !bus_wake |=> state_r == ltmc_pkg::ST_SLEEP)
		else $error("no sleep entry");
	a_sleep_inhibit: assert property (@(posedge core_clk_i) disable iff (rst_i)
		state_r == ltmc_pkg::ST_SLEEP |=> !regulator_inhibit_out_oe_o) else $error("inhibit driven in sleep");
	a_wake_ignored: assert property (@(posedge core_clk_i) disable iff (rst_i || por_s)
		state_r == ltmc_pkg::ST_STANDBY && !en_done |=> state_r == ltmc_pkg::ST_STANDBY)
		else $error("standby left without enable");
	a_por_release: assert property (@(posedge core_clk_i) disable iff (rst_i)
		por_s |=> ##1 !bus_dom_o && !rxd_oe_o) else $error("outputs driven under power-on reset");
endmodule

`default_nettype wire

// *** ltmc_bus_model.sv ***
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Single-wire bus with one remote node that the bench can make pull dominant.
module ltmc_bus_dev (
	// Local driver and remote node.
	input  wire logic dom_i,
	input  wire logic remote_dom_i,
	// Resolved line, low is dominant.
	output logic      bus_o
);
	// Wired-AND line: recessive unless some node pulls it down.
	assign bus_o = ~(dom_i | remote_dom_i);
endmodule

`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module testbench;
	logic       core_clk_i = 1'b0;
	logic       rst_i = 1'b1;
	logic       txd_i = 1'b1;
	logic       mode_select_i = 1'b0;
	logic       wake_i = 1'b1;
	logic       por_i = 1'b0;
	logic       ot_i = 1'b0;
	logic       slo_i = 1'b0;
	logic       shi_i = 1'b0;
	logic       remote_dom = 1'b0;
	logic       rxd_o, rxd_oe_o, spd_o, bus_i, dom_o, pu_o, wsrc_o, inh_o, inh_oe_o;
	logic [1:0] mode_o;
	logic [1:0] last_mode;
	logic [1:0] exp_q[$];
	logic       mon_en = 1'b0;
	int         fail_count = 0;
	int         tests_run = 0;
	int         n;

	always #12.5 core_clk_i = ~core_clk_i;

	ltmc_top #(.TXTO_CYC(50), .ENABLE_CYC(8), .DISABLE_CYC(30), .WAKE_CYC(10), .BUSWAKE_CYC(20))
	ltmc_top_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .txd_i(txd_i), .mode_select_i(mode_select_i),
		.rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o), .txd_strong_pd_o(spd_o), .bus_i(bus_i), .bus_dom_o(dom_o),
		.bus_pullup_o(pu_o), .bus_weak_src_o(wsrc_o), .wake_i(wake_i), .regulator_inhibit_out_o(inh_o),
		.regulator_inhibit_out_oe_o(inh_oe_o), .por_i(por_i), .over_temperature_shutdown_i(ot_i),
		.supply_monitor_low_i(slo_i), .supply_monitor_high_i(shi_i), .mode_o(mode_o));

	ltmc_bus_dev ltmc_bus_dev_i (.dom_i(dom_o), .remote_dom_i(remote_dom), .bus_o(bus_i));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [1:0] exp, input logic [1:0] got);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic step(input int k);
		repeat (k) @(negedge core_clk_i);
	endtask

	// Notes the expected mode for the monitor, then waits a bounded time for it.
	task automatic go_mode(input logic [1:0] m, input int lim);
		exp_q.push_back(m);
		for (int i = 0; i < lim && mode_o !== m; i++) @(negedge core_clk_i);
		chk("mode reached", m, mode_o);
	endtask

	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Every change of mode must match the oldest noted expectation.
	always @(negedge core_clk_i) begin
		if (mon_en && mode_o !== last_mode) begin
			if (exp_q.size() == 0)
				chk("unexpected mode", last_mode, mode_o);
			else
				chk("mode change", exp_q.pop_front(), mode_o);
		end
		last_mode <= mode_o;
	end

	initial begin
		repeat (20000) @(posedge core_clk_i);
		fail_count++;
		report_and_stop();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		n = $urandom(32'h6A1A);
		step(2);
		rst_i = 1'b0;
		mon_en = 1'b1;
		go_mode(2'h1, 10);
		chk("rxd release", 2'h0, {1'b0, rxd_oe_o});
		chk("txd strong pd", 2'h0, {1'b0, spd_o});
		chk("inhibit", 2'h3, {inh_oe_o, inh_o});
		chk("standby drive", 2'h0, {1'b0, dom_o});
		chk("standby pullup", 2'h2, {pu_o, wsrc_o});
		mode_select_i = 1'b1;
		go_mode(2'h2, 30);
		for (int i = 0; i < 6; i++) begin
			n = $urandom_range(20, 8);
			txd_i = 1'b0;
			remote_dom = $urandom_range(1, 0);
			step(n);
			chk("dominant drive", 2'h1, {1'b0, dom_o});
			chk("rx dominant", 2'h1, {1'b0, rxd_oe_o});
			chk("rxd level", 2'h0, {1'b0, rxd_o});
			txd_i = 1'b1;
			step(8);
			chk("recessive drive", 2'h0, {1'b0, dom_o});
			chk("rx follows bus", {1'b0, remote_dom}, {1'b0, rxd_oe_o});
			remote_dom = 1'b0;
		end
		txd_i = 1'b0;
		step(5);
		chk("before timeout", 2'h1, {1'b0, dom_o});
		step(55);
		chk("after timeout", 2'h0, {1'b0, dom_o});
		step(20);
		chk("timeout held", 2'h0, {1'b0, dom_o});
		txd_i = 1'b1;
		step(5);
		txd_i = 1'b0;
		step(5);
		chk("timeout recovered", 2'h1, {1'b0, dom_o});
		txd_i = 1'b1;
		ot_i = 1'b1;
		step(4);
		txd_i = 1'b0;
		step(5);
		chk("thermal block", 2'h0, {1'b0, dom_o});
		ot_i = 1'b0;
		step(6);
		chk("thermal wait high", 2'h0, {1'b0, dom_o});
		txd_i = 1'b1;
		step(5);
		txd_i = 1'b0;
		step(5);
		chk("thermal recovered", 2'h1, {1'b0, dom_o});
		slo_i = 1'b1;
		step(5);
		chk("supply block", 2'h0, {1'b0, dom_o});
		remote_dom = 1'b1;
		step(5);
		chk("supply rx alive", 2'h1, {1'b0, rxd_oe_o});
		chk("supply mode", 2'h2, mode_o);
		remote_dom = 1'b0;
		slo_i = 1'b0;
		shi_i = 1'b1;
		step(5);
		chk("supply recovered", 2'h1, {1'b0, dom_o});
		txd_i = 1'b1;
		shi_i = 1'b0;
		wake_i = 1'b0;
		step(30);
		chk("wake ignored normal", 2'h2, mode_o);
		mode_select_i = 1'b0;
		go_mode(2'h3, 60);
		chk("sleep inhibit", 2'h0, {1'b0, inh_oe_o});
		chk("sleep bus", 2'h1, {pu_o, wsrc_o});
		wake_i = 1'b1;
		step(5);
		wake_i = 1'b0;
		step(4);
		wake_i = 1'b1;
		step(20);
		chk("short wake", 2'h3, mode_o);
		wake_i = 1'b0;
		go_mode(2'h1, 40);
		chk("local wake pins", 2'h3, {rxd_oe_o, spd_o});
		wake_i = 1'b1;
		remote_dom = 1'b1;
		step(30);
		remote_dom = 1'b0;
		step(10);
		chk("standby unchanged", 2'h3, {rxd_oe_o, spd_o});
		mode_select_i = 1'b1;
		step(4);
		chk("early release", 2'h0, {rxd_oe_o, spd_o});
		chk("still standby", 2'h1, mode_o);
		go_mode(2'h2, 30);
		mode_select_i = 1'b0;
		wake_i = 1'b0;
		go_mode(2'h1, 60);
		chk("window wake pins", 2'h3, {rxd_oe_o, spd_o});
		wake_i = 1'b1;
		mode_select_i = 1'b1;
		go_mode(2'h2, 30);
		mode_select_i = 1'b0;
		go_mode(2'h3, 60);
		remote_dom = 1'b1;
		step(30);
		chk("no edge yet", 2'h3, mode_o);
		remote_dom = 1'b0;
		go_mode(2'h1, 20);
		chk("bus wake pins", 2'h2, {rxd_oe_o, spd_o});
		por_i = 1'b1;
		go_mode(2'h0, 10);
		chk("unpowered outs", 2'h0, {inh_oe_o, dom_o});
		chk("unpowered rx", 2'h0, {rxd_oe_o, spd_o});
		por_i = 1'b0;
		go_mode(2'h1, 10);
		mode_select_i = 1'b1;
		go_mode(2'h2, 30);
		mode_select_i = 1'b0;
		go_mode(2'h3, 60);
		mode_select_i = 1'b1;
		go_mode(2'h2, 30);
		chk("normal from sleep", 2'h2, {pu_o, wsrc_o});
		report_and_stop();
	end
endmodule

`default_nettype wire
